// ### logic/out_prot_pkg.sv
// types for the output protection and port control block
package out_prot_pkg;
	typedef enum logic [1:0] {BLOCK_OFF, BLOCK_STICKY, BLOCK_TRANSPARENT} block_mode_t;
	typedef enum logic {PORT_BLOCK_FAULT, PORT_GENERAL_IO} port_mode_t;
	typedef enum logic [2:0] {FSRC_OFF, FSRC_QUES, FSRC_OPER, FSRC_ESB, FSRC_RQS} fault_src_t;
	typedef enum logic {POL_SAME, POL_SWAPPED} polarity_t;
	typedef struct packed {
		logic        relay_set;
		logic        relay_val;
		logic        pol_set;
		polarity_t   pol_val;
		logic        block_mode_set;
		block_mode_t block_mode_val;
		logic        port_mode_set;
		port_mode_t  port_mode_val;
		logic        port_value_set;
		logic [3:0]  port_value_val;
		logic        fault_src_set;
		fault_src_t  fault_src_val;
		logic        trip_en_set;
		logic        trip_en_val;
		logic        out_set;
		logic        out_val;
		logic        clear;
	} cmd_t;
endpackage : out_prot_pkg

// ### logic/out_prot_regs.svh
// constants for the output protection and port control block
`ifndef OUT_PROT_REGS_SVH
`define OUT_PROT_REGS_SVH
`define PORT_VALUE_MAX       3'h7
`define PORT_BIT_PIN3_DIR    2
`define RELAY_SETTLE_NS      20000
`define CLK_PERIOD_NS        10
`define RELAY_SETTLE_CYC     ((`RELAY_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CURR_RESET_DIVISOR   10
`define STB_BIT_QUES         3
`define STB_BIT_ESB          5
`define STB_BIT_RQS          6
`define STB_BIT_OPER         7
`endif

// ### logic/output_protection_port_ctrl.sv
// output relay, block input, overcurrent latch, current levels and digital port
// What this block does
// - relay closes when on, open after reset
// - relay state independent of output enable
// - relay commands rejected without relay option
// - polarity same or swapped, same after reset
// - zero voltage while polarity relays switch, always on
// - sticky mode latches disable on pin low
// - sticky latch clears only when pin inactive, or on a mode set outside sticky mode
// - transparent mode follows pin without latching
// - block mode off ignores the pin
// - block mode kept in non-volatile storage
// - immediate current applied, resets to tenth max
// - pending current copied on initiated trigger
// - overcurrent trip disables output, sets flag
// - overcurrent clear only after cause gone
// - io mode drives pins one, two
// - third pin output unless bit two high
// - readback returns bits 0-1, pin three level
// - values 0 to 7, acted on only io
// - port function kept in non-volatile storage
// - clear restores pre-fault output state
// - fault output source selectable or none
`timescale 1ns/1ps
`include "out_prot_regs.svh"

module output_protection_port_ctrl #(
	parameter int CURR_W       = 16,
	parameter int CURR_MAX     = 16'hffff,
	parameter int SETTLE_CYC   = `RELAY_SETTLE_CYC
) (
	// clock and reset
	input  wire logic                 mclk_in,
	input  wire logic                 rstn_in,
	// host commands
	input  wire out_prot_pkg::cmd_t   cmd_in,
	input  wire logic                 relay_fitted_in,
	input  wire logic                 curr_imm_set_in,
	input  wire logic [CURR_W-1:0]    curr_imm_in,
	input  wire logic                 curr_trig_set_in,
	input  wire logic [CURR_W-1:0]    curr_trig_in,
	input  wire logic                 trigger_in,
	input  wire logic                 initiated_in,
	// non-volatile store contents loaded after reset release
	input  wire out_prot_pkg::block_mode_t nv_block_mode_in,
	input  wire out_prot_pkg::port_mode_t  nv_port_mode_in,
	// source status
	input  wire logic                 const_current_in,
	input  wire logic [7:0]           status_byte_in,
	// port pins
	input  wire logic                 disable_request_pin_in,
	input  wire logic                 pin3_in,
	output logic [1:0]                pin12_out,
	output logic                      pin3_out,
	output logic                      pin3_oe_n_out,
	// output control
	output logic                      relay_closed_out,
	output out_prot_pkg::polarity_t   relay_polarity_out,
	output logic                      output_enabled_out,
	output logic                      zero_voltage_out,
	output logic                      pol_busy_out,
	output logic [CURR_W-1:0]         curr_level_out,
	output logic                      overcurrent_flag_out,
	output logic                      fault_signal_output_out,
	// host readback
	output logic [2:0]                port_value_rd_out,
	output logic                      cmd_error_out,
	output out_prot_pkg::block_mode_t nv_block_mode_out,
	output out_prot_pkg::port_mode_t  nv_port_mode_out
);

	if (CURR_W < 4 || CURR_W > 32 || SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_bad_params
		$error("output_protection_port_ctrl: bad parameters");
	end

	localparam logic [CURR_W-1:0] CURR_RST = CURR_W'(CURR_MAX / `CURR_RESET_DIVISOR);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [2:0] dis_sync_ff;
	logic [2:0] p3_sync_ff;
	logic       dis_low_ff;
	logic       p3_lvl_ff;

	always_ff @(posedge mclk_in) begin
		dis_sync_ff <= {dis_sync_ff[1:0], disable_request_pin_in};
		p3_sync_ff  <= {p3_sync_ff[1:0], pin3_in};
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			dis_low_ff <= 1'b0;
			p3_lvl_ff  <= 1'b0;
		end else begin
			if (dis_sync_ff[1] == dis_sync_ff[2])
				dis_low_ff <= ~dis_sync_ff[2];
			if (p3_sync_ff[1] == p3_sync_ff[2])
				p3_lvl_ff <= p3_sync_ff[2];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// mode registers, non-volatile settings loaded after reset release

	out_prot_pkg::block_mode_t block_mode_ff;
	out_prot_pkg::port_mode_t  port_mode_ff;
	out_prot_pkg::fault_src_t  fault_src_ff;
	logic                      loaded_ff;

	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			block_mode_ff <= out_prot_pkg::BLOCK_OFF;
			port_mode_ff  <= out_prot_pkg::PORT_BLOCK_FAULT;
			fault_src_ff  <= out_prot_pkg::FSRC_OFF;
			loaded_ff     <= 1'b0;
		end else if (!loaded_ff) begin
			block_mode_ff <= nv_block_mode_in;
			port_mode_ff  <= nv_port_mode_in;
			loaded_ff     <= 1'b1;
		end else begin
			if (cmd_in.block_mode_set)
				block_mode_ff <= cmd_in.block_mode_val;
			if (cmd_in.port_mode_set)
				port_mode_ff <= cmd_in.port_mode_val;
			if (cmd_in.fault_src_set)
				fault_src_ff <= cmd_in.fault_src_val;
		end
	end

	assign nv_block_mode_out = block_mode_ff;
	assign nv_port_mode_out  = port_mode_ff;

	////////////////////////////////////////////////////////////////////////////////
	// relay state and polarity

	logic                    relay_ff;
	out_prot_pkg::polarity_t pol_ff;
	logic [15:0]             settle_ff;
	logic                    err_ff;
	logic                    relay_cmd;
	logic                    pol_change;

	assign relay_cmd  = cmd_in.relay_set | cmd_in.pol_set;
	assign pol_change = cmd_in.pol_set & relay_fitted_in & (cmd_in.pol_val != pol_ff);

	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			relay_ff <= 1'b0;
			pol_ff   <= out_prot_pkg::POL_SAME;
		end else if (relay_fitted_in) begin
			if (cmd_in.relay_set)
				relay_ff <= cmd_in.relay_val;
			if (cmd_in.pol_set)
				pol_ff <= cmd_in.pol_val;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in)
			err_ff <= 1'b0;
		else
			err_ff <= (relay_cmd & ~relay_fitted_in)
				| (cmd_in.port_value_set & (cmd_in.port_value_val > 4'({`PORT_VALUE_MAX})));
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in)
			settle_ff <= 16'h0000;
		else if (pol_change)
			settle_ff <= 16'(SETTLE_CYC);
		else if (settle_ff != 16'h0000)
			settle_ff <= settle_ff - 16'h0001;
	end

	assign relay_closed_out   = relay_ff;
	assign relay_polarity_out = pol_ff;
	assign pol_busy_out       = (settle_ff != 16'h0000);
	assign cmd_error_out      = err_ff;

	////////////////////////////////////////////////////////////////////////////////
	// output enable, block latch and overcurrent trip

	logic out_ff;
	logic sticky_ff;
	logic trip_ff;
	logic trip_en_ff;
	logic blocked;

	always_ff @(posedge mclk_in) begin
		if (!rstn_in)
			out_ff <= 1'b0;
		else if (cmd_in.out_set)
			out_ff <= cmd_in.out_val;
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in)
			trip_en_ff <= 1'b0;
		else if (cmd_in.trip_en_set)
			trip_en_ff <= cmd_in.trip_en_val;
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in)
			sticky_ff <= 1'b0;
		else if (block_mode_ff == out_prot_pkg::BLOCK_STICKY && dis_low_ff)
			sticky_ff <= 1'b1;
		else if (cmd_in.clear && !dis_low_ff)
			sticky_ff <= 1'b0;
		else if (block_mode_ff != out_prot_pkg::BLOCK_STICKY && cmd_in.block_mode_set)
			sticky_ff <= 1'b0;
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in)
			trip_ff <= 1'b0;
		else if (trip_en_ff && const_current_in && out_ff)
			trip_ff <= 1'b1;
		else if (cmd_in.clear && !const_current_in)
			trip_ff <= 1'b0;
	end

	always_comb begin
		unique case (block_mode_ff)
			out_prot_pkg::BLOCK_STICKY:      blocked = sticky_ff;
			out_prot_pkg::BLOCK_TRANSPARENT: blocked = dis_low_ff;
			out_prot_pkg::BLOCK_OFF:         blocked = 1'b0;
			default:                         blocked = 1'b0;
		endcase
	end

	// programmed state is kept, so clearing the latches restores it
	assign output_enabled_out   = out_ff & ~blocked & ~trip_ff;
	assign zero_voltage_out     = ~output_enabled_out | pol_busy_out;
	assign overcurrent_flag_out = trip_ff;

	always_comb begin
		unique case (fault_src_ff)
			out_prot_pkg::FSRC_QUES: fault_signal_output_out = status_byte_in[`STB_BIT_QUES];
			out_prot_pkg::FSRC_OPER: fault_signal_output_out = status_byte_in[`STB_BIT_OPER];
			out_prot_pkg::FSRC_ESB:  fault_signal_output_out = status_byte_in[`STB_BIT_ESB];
			out_prot_pkg::FSRC_RQS:  fault_signal_output_out = status_byte_in[`STB_BIT_RQS];
			default:                 fault_signal_output_out = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// current levels

	logic [CURR_W-1:0] curr_imm_ff;
	logic [CURR_W-1:0] curr_trig_ff;

	always_ff @(posedge mclk_in) begin
		if (!rstn_in)
			curr_trig_ff <= CURR_RST;
		else if (curr_trig_set_in)
			curr_trig_ff <= curr_trig_in;
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in)
			curr_imm_ff <= CURR_RST;
		else if (trigger_in && initiated_in)
			curr_imm_ff <= curr_trig_ff;
		else if (curr_imm_set_in)
			curr_imm_ff <= curr_imm_in;
	end

	assign curr_level_out = curr_imm_ff;

	////////////////////////////////////////////////////////////////////////////////
	// digital port

	logic [2:0] port_val_ff;
	logic       io_mode;

	assign io_mode = (port_mode_ff == out_prot_pkg::PORT_GENERAL_IO);

	always_ff @(posedge mclk_in) begin
		if (!rstn_in)
			port_val_ff <= 3'h0;
		else if (cmd_in.port_value_set && io_mode
			&& cmd_in.port_value_val <= 4'({`PORT_VALUE_MAX}))
			port_val_ff <= cmd_in.port_value_val[2:0];
	end

	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			pin12_out     <= 2'h0;
			pin3_out      <= 1'b0;
			pin3_oe_n_out <= 1'b1;
		end else if (io_mode) begin
			pin12_out     <= port_val_ff[1:0];
			pin3_out      <= 1'b0;
			pin3_oe_n_out <= port_val_ff[`PORT_BIT_PIN3_DIR];
		end else begin
			pin12_out     <= {1'b0, fault_signal_output_out};
			pin3_out      <= 1'b0;
			pin3_oe_n_out <= 1'b1;
		end
	end

	assign port_value_rd_out = {p3_lvl_ff, port_val_ff[1:0]};

endmodule : output_protection_port_ctrl

// ### sim/out_prot_props.sv
// property checker for the output protection block
`timescale 1ns/1ps
module out_prot_props (
	// clock and reset
	input wire logic                      mclk_in,
	input wire logic                      rstn_in,
	// inputs
	input wire out_prot_pkg::cmd_t        cmd_in,
	input wire logic                      relay_fitted_in,
	input wire logic                      const_current_in,
	input wire logic                      disable_request_pin_in,
	// outputs
	input wire logic [1:0]                pin12_out,
	input wire logic                      pin3_oe_n_out,
	input wire logic                      relay_closed_out,
	input wire out_prot_pkg::polarity_t   relay_polarity_out,
	input wire logic                      output_enabled_out,
	input wire logic                      zero_voltage_out,
	input wire logic                      pol_busy_out,
	input wire logic                      overcurrent_flag_out,
	input wire logic                      cmd_error_out,
	input wire out_prot_pkg::block_mode_t nv_block_mode_out,
	input wire out_prot_pkg::port_mode_t  nv_port_mode_out
);
	default clocking @(posedge mclk_in);
	endclocking
	default disable iff (!rstn_in);
	////////////////////////////////////////////////////////////////////////////////
	a_relay_refused: assert property (cmd_in.relay_set && !relay_fitted_in |=> cmd_error_out)
		else $error("relay cmd taken");
	a_relay_follow: assert property (cmd_in.relay_set && relay_fitted_in
		|=> relay_closed_out == $past(cmd_in.relay_val)) else $error("relay wrong");
	a_pol_zero: assert property (cmd_in.pol_set && relay_fitted_in
		&& cmd_in.pol_val != relay_polarity_out |=> pol_busy_out && zero_voltage_out)
		else $error("no zero");
	a_pol_settle: assert property ($changed(relay_polarity_out)
		|-> pol_busy_out[*3] ##[1:4] !pol_busy_out) else $error("settle wrong");
	a_transp_block: assert property ((nv_block_mode_out == out_prot_pkg::BLOCK_TRANSPARENT
		&& !disable_request_pin_in)[*6] |-> !output_enabled_out) else $error("follow wrong");
	a_trip_off: assert property ($rose(overcurrent_flag_out)
		|-> $past(const_current_in) && !output_enabled_out) else $error("trip on");
	a_trip_clear: assert property ($fell(overcurrent_flag_out)
		|-> $past(cmd_in.clear) && !$past(const_current_in)) else $error("clear wrong");
	a_port_drive: assert property (nv_port_mode_out == out_prot_pkg::PORT_GENERAL_IO
		&& cmd_in.port_value_set && !cmd_in.port_value_val[3] |-> ##2
		{pin3_oe_n_out, pin12_out} == $past(cmd_in.port_value_val[2:0], 2)) else $error("port");
endmodule : out_prot_props
bind output_protection_port_ctrl out_prot_props u_out_prot_props (.*);

// ### sim/pin_partner.sv
// far side model: inhibit source and device on the third pin
`timescale 1ns/1ps
module pin_partner (
	// from the bench
	input wire logic dis_low_in,
	input wire logic pin3_lvl_in,
	// from the block
	input wire logic blk_pin3_in,
	input wire logic blk_oe_n_in,
	// to the block
	output logic     dis_pin_out,
	output logic     pin3_wire_out
);
	// inhibit line is low true
	assign dis_pin_out = !dis_low_in;
	// block drive wins while enabled, else the far device drives
	assign pin3_wire_out = blk_oe_n_in ? pin3_lvl_in : blk_pin3_in;
endmodule : pin_partner

// ### sim/testbench.sv
// bench for the output protection block
`timescale 1ns/1ps
module testbench;
	logic mclk_in = 1'b0, rstn_in = 1'b0, relay_fitted_in = 1'b0, dis_low = 1'b0, lvl = 1'b0;
	logic curr_imm_set_in = 1'b0, curr_trig_set_in = 1'b0, trigger_in = 1'b0;
	logic initiated_in = 1'b0, const_current_in = 1'b0, disable_request_pin_in, pin3_in;
	logic pin3_out, pin3_oe_n_out, relay_closed_out, output_enabled_out, zero_voltage_out;
	logic pol_busy_out, overcurrent_flag_out, fault_signal_output_out, cmd_error_out;
	logic [15:0] curr_imm_in = 16'h0, curr_trig_in = 16'h0, curr_level_out;
	logic [7:0] status_byte_in = 8'h0;
	logic [2:0] port_value_rd_out;
	logic [1:0] pin12_out;
	out_prot_pkg::cmd_t cmd_in = '0, c = '0;
	out_prot_pkg::polarity_t relay_polarity_out;
	out_prot_pkg::block_mode_t nv_block_mode_in = out_prot_pkg::BLOCK_OFF, nv_block_mode_out;
	out_prot_pkg::port_mode_t nv_port_mode_in = out_prot_pkg::PORT_BLOCK_FAULT, nv_port_mode_out;
	int errors = 0, checked = 0;
	output_protection_port_ctrl #(.SETTLE_CYC(4)) u_output_protection_port_ctrl (.*);
	pin_partner u_pin_partner (.dis_low_in(dis_low), .pin3_lvl_in(lvl), .blk_pin3_in(pin3_out),
		.blk_oe_n_in(pin3_oe_n_out), .dis_pin_out(disable_request_pin_in), .pin3_wire_out(pin3_in));
	always #5 mclk_in = ~mclk_in;
	////////////////////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask : tick
	task go();
		@(posedge mclk_in);
		cmd_in <= c;
		@(posedge mclk_in);
		cmd_in <= '0;
		c = '0;
		#1;
	endtask : go
	task pin(input logic v);
		@(posedge mclk_in);
		dis_low <= v;
		tick(8);
	endtask : pin
	task stop_test();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	////////////////////////////////////////////////////////////////////////////////
	task t_relay();
		chk("relay", relay_closed_out, 1'b0);
		chk("polarity", relay_polarity_out, out_prot_pkg::POL_SAME);
		chk("current", curr_level_out, 16'h1999);
		c.relay_set = 1'b1;
		c.relay_val = 1'b1;
		go();
		chk("error", cmd_error_out, 1'b1);
		chk("relay", relay_closed_out, 1'b0);
		@(posedge mclk_in);
		relay_fitted_in <= 1'b1;
		c.relay_set = 1'b1;
		c.relay_val = 1'b1;
		go();
		chk("relay", relay_closed_out, 1'b1);
		c.out_set = 1'b1;
		c.out_val = 1'b1;
		go();
		chk("relay", relay_closed_out, 1'b1);
		chk("enabled", output_enabled_out, 1'b1);
	endtask : t_relay
	task t_pol();
		c.pol_set = 1'b1;
		c.pol_val = out_prot_pkg::POL_SWAPPED;
		go();
		chk("polarity", relay_polarity_out, out_prot_pkg::POL_SWAPPED);
		chk("zero", zero_voltage_out, 1'b1);
		for (int i = 0; i < 20 && pol_busy_out !== 1'b0; i++)
			tick(1);
		chk("busy", pol_busy_out, 1'b0);
		if (pol_busy_out !== 1'b0)
			stop_test();
		chk("zero", zero_voltage_out, 1'b0);
	endtask : t_pol
	task t_block();
		c.block_mode_set = 1'b1;
		c.block_mode_val = out_prot_pkg::BLOCK_TRANSPARENT;
		go();
		chk("mode", nv_block_mode_out, out_prot_pkg::BLOCK_TRANSPARENT);
		pin(1'b1);
		chk("enabled", output_enabled_out, 1'b0);
		pin(1'b0);
		chk("enabled", output_enabled_out, 1'b1);
		c.block_mode_set = 1'b1;
		c.block_mode_val = out_prot_pkg::BLOCK_STICKY;
		go();
		pin(1'b1);
		c.clear = 1'b1;
		go();
		pin(1'b0);
		chk("latched", output_enabled_out, 1'b0);
		c.clear = 1'b1;
		go();
		chk("enabled", output_enabled_out, 1'b1);
		c.block_mode_set = 1'b1;
		c.block_mode_val = out_prot_pkg::BLOCK_OFF;
		go();
		pin(1'b1);
		chk("enabled", output_enabled_out, 1'b1);
		pin(1'b0);
	endtask : t_block
	task t_curr();
		@(posedge mclk_in);
		curr_imm_set_in <= 1'b1;
		curr_imm_in <= 16'h1234;
		curr_trig_set_in <= 1'b1;
		curr_trig_in <= 16'h0abc;
		trigger_in <= 1'b1;
		@(posedge mclk_in);
		curr_imm_set_in <= 1'b0;
		curr_trig_set_in <= 1'b0;
		tick(1);
		chk("current", curr_level_out, 16'h1234);
		@(posedge mclk_in);
		initiated_in <= 1'b1;
		@(posedge mclk_in);
		trigger_in <= 1'b0;
		initiated_in <= 1'b0;
		#1;
		chk("current", curr_level_out, 16'h0abc);
	endtask : t_curr
	task t_trip();
		c.trip_en_set = 1'b1;
		c.trip_en_val = 1'b1;
		go();
		@(posedge mclk_in);
		const_current_in <= 1'b1;
		tick(3);
		chk("flag", overcurrent_flag_out, 1'b1);
		chk("enabled", output_enabled_out, 1'b0);
		c.clear = 1'b1;
		go();
		chk("flag", overcurrent_flag_out, 1'b1);
		@(posedge mclk_in);
		const_current_in <= 1'b0;
		c.clear = 1'b1;
		go();
		chk("flag", overcurrent_flag_out, 1'b0);
		chk("enabled", output_enabled_out, 1'b1);
	endtask : t_trip
	task fsrc(input out_prot_pkg::fault_src_t s, input logic e);
		c.fault_src_set = 1'b1;
		c.fault_src_val = s;
		go();
		chk("fault", fault_signal_output_out, e);
		tick(1);
		chk("pin1", pin12_out[0], e);
	endtask : fsrc
	task t_fault();
		@(posedge mclk_in);
		status_byte_in <= 8'h80;
		fsrc(out_prot_pkg::FSRC_OPER, 1'b1);
		fsrc(out_prot_pkg::FSRC_QUES, 1'b0);
		@(posedge mclk_in);
		status_byte_in <= 8'h68;
		fsrc(out_prot_pkg::FSRC_ESB, 1'b1);
		fsrc(out_prot_pkg::FSRC_RQS, 1'b1);
		fsrc(out_prot_pkg::FSRC_QUES, 1'b1);
		fsrc(out_prot_pkg::FSRC_OFF, 1'b0);
	endtask : t_fault
	task t_nv();
		@(posedge mclk_in);
		rstn_in <= 1'b0;
		nv_block_mode_in <= out_prot_pkg::BLOCK_STICKY;
		nv_port_mode_in <= out_prot_pkg::PORT_GENERAL_IO;
		tick(3);
		chk("relay", relay_closed_out, 1'b0);
		chk("polarity", relay_polarity_out, out_prot_pkg::POL_SAME);
		chk("current", curr_level_out, 16'h1999);
		@(posedge mclk_in);
		rstn_in <= 1'b1;
		tick(2);
		chk("mode", nv_block_mode_out, out_prot_pkg::BLOCK_STICKY);
		chk("func", nv_port_mode_out, out_prot_pkg::PORT_GENERAL_IO);
		chk("pin3 dir", pin3_oe_n_out, 1'b0);
		chk("pin3", pin3_out, 1'b0);
	endtask : t_nv
	task t_port();
		c.port_value_set = 1'b1;
		c.port_value_val = 4'h3;
		go();
		chk("pin2", pin12_out[1], 1'b0);
		c.port_mode_set = 1'b1;
		c.port_mode_val = out_prot_pkg::PORT_GENERAL_IO;
		go();
		chk("func", nv_port_mode_out, out_prot_pkg::PORT_GENERAL_IO);
		for (int v = 0; v < 8; v++) begin
			@(posedge mclk_in);
			lvl <= ~v[0];
			c.port_value_set = 1'b1;
			c.port_value_val = v[3:0];
			go();
			tick(5);
			chk("pins", {pin3_oe_n_out, pin12_out}, v[2:0]);
			chk("readback", port_value_rd_out, {v[2] & ~v[0], v[1:0]});
		end
		c.port_value_set = 1'b1;
		c.port_value_val = 4'h8;
		go();
		chk("error", cmd_error_out, 1'b1);
		chk("readback", port_value_rd_out[1:0], 2'h3);
	endtask : t_port
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge mclk_in);
		rstn_in <= 1'b1;
		tick(2);
		t_relay();
		t_pol();
		t_block();
		t_curr();
		t_trip();
		t_fault();
		t_port();
		t_nv();
		stop_test();
	end
endmodule : testbench
